// ### fism_pkg.sv
/*
 * Constants shared by the fault interrupt status, mask and sense block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses four times
 * the register index, and 8-bit registers in the low byte of each word.
 */
package fism_pkg;

  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;
  localparam int unsigned REG_W      = 8;
  localparam int unsigned IDX_W      = 6;
  localparam int unsigned LIN_N      = 6;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_BUCK_LIVE  = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_EVT3_FLAGS = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_EVT3_MASKS = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_EVT3_LIVE  = 6'h10;
  localparam logic [IDX_W-1:0] IDX_LIN_FLAGS  = 6'h11;
  localparam logic [IDX_W-1:0] IDX_LIN_MASKS  = 6'h12;
  localparam logic [IDX_W-1:0] IDX_LIN_LIVE   = 6'h13;

  // Bit positions.
  localparam int unsigned BIT_BUCK3      = 4;
  localparam int unsigned BIT_BUCK2      = 3;
  localparam int unsigned BIT_BUCK1_HI   = 1;
  localparam int unsigned BIT_BUCK1_LO   = 0;
  localparam int unsigned BIT_FUSE_ERR   = 7;
  localparam int unsigned BIT_FUSE_DONE  = 6;
  localparam int unsigned BIT_BOOST      = 0;
  localparam int unsigned BIT_MASK3_SPARE = 2;

  // Implemented bits and reset values.
  localparam logic [REG_W-1:0] EVT3_IMPL     = 8'hc1;
  localparam logic [REG_W-1:0] EVT3_MASK_RST = 8'hc5;
  localparam logic [REG_W-1:0] LIN_IMPL      = 8'h3f;
  localparam logic [REG_W-1:0] LIN_MASK_RST  = 8'h3f;
  localparam logic [REG_W-1:0] REG_ZERO      = 8'h00;

  // Byte lane of the register inside the data word.
  localparam int unsigned LANE0 = 0;
  localparam int unsigned ADDR_LSB = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : fism_pkg

// ### fism_flag_cell.sv
/*
 * One latched event flag with write-one-to-clear.
 * Assumes set and clear requests come from logic on mclk.
 */
`timescale 1ns/10ps
module fism_flag_cell
  import fism_pkg::*;
(
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic set_evt,
  input  wire logic clr_req,
  output logic      flag_reg
);

  // A set in the same cycle as a clear keeps the flag.
  always_ff @(posedge mclk) begin
    if (srst) begin
      flag_reg <= 1'b0;
    end else if (set_evt) begin
      flag_reg <= 1'b1; // [RULE15]
    end else if (clr_req) begin
      flag_reg <= 1'b0; // [RULE7]
    end
  end

  property p_set_wins;
    @(posedge mclk) disable iff (srst)
      set_evt |=> flag_reg;
  endproperty
  a_set_wins : assert property (p_set_wins) else $error("flag lost a set event"); // [RULE15]

endmodule // fism_flag_cell

// ### fism_top.sv
/*
 * Fault interrupt status, mask and sense logic with an AXI4-Lite slave.
 * Assumes fault and fuse-sequence conditions arrive as asynchronous levels
 * and the host services the active-low interrupt pin over the bus.
 */
// Function
// [RULE1] Buck live bits: buck3 at 4, buck2 at 3, buck1 at 1 and 0.
// [RULE2] Live bits show the actual regulator state from reset; unused bits read zero.
// [RULE3] Live registers are read-only and mirror present conditions without latching.
// [RULE4] Bit 7 of the event flags sets when a fuse error is detected.
// [RULE5] Bit 6 of the event flags sets once the automatic fuse blow completes.
// [RULE6] Bit 0 of the event flags sets while the boost is in current limit.
// [RULE7] Flags clear only on a written one; reset to zero; bits 5 to 1 read zero.
// [RULE8] Mask bit 0 lets its flag reach the interrupt pin; mask bit 1 blocks it.
// [RULE9] Event masks at bits 7, 6, 0 reset to one; bit 2 also resets to one.
// [RULE10] Event live register: boost fault at bit 0, fuse error at bit 7.
// [RULE11] Live bit 6 stays one while the automatic fuse blow is running.
// [RULE12] Host avoids fuse programming registers while live bit 6 reads one.
// [RULE13] Linear fault register holds six flags, each cleared by a written one.
// [RULE14] Interrupt pin low while any unmasked flag is set, released otherwise.
// [RULE15] Flags latch the cycle their condition is true; set beats clear.
`timescale 1ns/10ps
module fism_top
  import fism_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [AXI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  buck1_overcurrent_live,
  input  wire logic                  buck2_overcurrent_live,
  input  wire logic                  buck3_overcurrent_live,
  input  wire logic                  boost_overcurrent_live,
  input  wire logic                  fuse_error_live,
  input  wire logic                  fuse_blow_running_live,
  input  wire logic [LIN_N-1:0]      linear_overcurrent_live,
  output logic                       interrupt_out_n,
  output logic                       irq
);

  localparam int unsigned COND_N = 6 + LIN_N;

  logic [COND_N-1:0]     cond_sync1_reg;
  logic [COND_N-1:0]     cond_sync2_reg;
  logic                  blow_prev_reg;
  logic                  buck1_s;
  logic                  buck2_s;
  logic                  buck3_s;
  logic                  boost_s;
  logic                  ferr_s;
  logic                  frun_s;
  logic [LIN_N-1:0]      lin_s;
  logic                  blow_done_evt;
  logic [REG_W-1:0]      buck_live;
  logic [REG_W-1:0]      evt3_live;
  logic [REG_W-1:0]      lin_live;
  logic [REG_W-1:0]      evt3_flags;
  logic [REG_W-1:0]      lin_flags;
  logic [REG_W-1:0]      evt3_mask_reg;
  logic [REG_W-1:0]      lin_mask_reg;
  logic [REG_W-1:0]      evt3_set;
  logic [REG_W-1:0]      lin_set;
  logic [REG_W-1:0]      evt3_clr;
  logic [REG_W-1:0]      lin_clr;
  logic                  pending;
  logic                  aw_held_reg;
  logic                  w_held_reg;
  logic [IDX_W-1:0]      wr_idx_reg;
  logic [REG_W-1:0]      wr_data_reg;
  logic                  wr_lane_reg;
  logic                  wr_fire;
  logic                  wr_byte;
  logic                  wr_mapped;
  logic                  ar_fire;
  logic [IDX_W-1:0]      rd_idx;
  logic [REG_W-1:0]      rd_byte;
  logic                  rd_mapped;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Two-stage synchronisers. They are not reset so that the live bits
  // carry the real regulator state straight out of reset.
  always_ff @(posedge mclk) begin
    cond_sync1_reg <= {linear_overcurrent_live, fuse_blow_running_live, fuse_error_live,
                       boost_overcurrent_live, buck3_overcurrent_live,
                       buck2_overcurrent_live, buck1_overcurrent_live};
    cond_sync2_reg <= cond_sync1_reg; // [RULE2]
  end

  assign buck1_s = cond_sync2_reg[0];
  assign buck2_s = cond_sync2_reg[1];
  assign buck3_s = cond_sync2_reg[2];
  assign boost_s = cond_sync2_reg[3];
  assign ferr_s  = cond_sync2_reg[4];
  assign frun_s  = cond_sync2_reg[5];
  assign lin_s   = cond_sync2_reg[COND_N-1:6];

  // Completion of the fuse blow is the falling edge of the running level.
  always_ff @(posedge mclk) begin
    if (srst) begin
      blow_prev_reg <= 1'b0;
    end else begin
      blow_prev_reg <= frun_s;
    end
  end

  assign blow_done_evt = blow_prev_reg & ~frun_s;

  // Live views; unimplemented positions are zero.
  always_comb begin
    buck_live               = REG_ZERO;
    buck_live[BIT_BUCK3]    = buck3_s; // [RULE1]
    buck_live[BIT_BUCK2]    = buck2_s;
    buck_live[BIT_BUCK1_HI] = buck1_s;
    buck_live[BIT_BUCK1_LO] = buck1_s;
    evt3_live                = REG_ZERO;
    evt3_live[BIT_FUSE_ERR]  = ferr_s; // [RULE10]
    evt3_live[BIT_FUSE_DONE] = frun_s; // [RULE11]
    evt3_live[BIT_BOOST]     = boost_s; // [RULE10]
    lin_live                 = REG_ZERO;
    lin_live[LIN_N-1:0]      = lin_s; // [RULE3]
  end

  // Event sources for the latched flags.
  always_comb begin
    evt3_set                = REG_ZERO;
    evt3_set[BIT_FUSE_ERR]  = ferr_s; // [RULE4]
    evt3_set[BIT_FUSE_DONE] = blow_done_evt; // [RULE5]
    evt3_set[BIT_BOOST]     = boost_s; // [RULE6]
    lin_set                 = REG_ZERO;
    lin_set[LIN_N-1:0]      = lin_s; // [RULE13]
  end

  // Write-one-to-clear requests from the bus.
  assign wr_byte  = wr_fire & wr_lane_reg;
  assign evt3_clr = (wr_byte && wr_idx_reg == IDX_EVT3_FLAGS) ? wr_data_reg : REG_ZERO; // [RULE7]
  assign lin_clr  = (wr_byte && wr_idx_reg == IDX_LIN_FLAGS) ? wr_data_reg : REG_ZERO;

  genvar gi;
  generate
    for (gi = 0; gi < REG_W; gi++) begin : g_flags
      if (EVT3_IMPL[gi]) begin : g_evt3
        fism_flag_cell u_cell (
          .mclk     (mclk),
          .srst     (srst),
          .set_evt  (evt3_set[gi]),
          .clr_req  (evt3_clr[gi]),
          .flag_reg (evt3_flags[gi])
        );
      end else begin : g_evt3_none
        assign evt3_flags[gi] = 1'b0; // [RULE7]
      end
      if (LIN_IMPL[gi]) begin : g_lin
        fism_flag_cell u_cell (
          .mclk     (mclk),
          .srst     (srst),
          .set_evt  (lin_set[gi]),
          .clr_req  (lin_clr[gi]),
          .flag_reg (lin_flags[gi])
        );
      end else begin : g_lin_none
        assign lin_flags[gi] = 1'b0;
      end
    end
  endgenerate

  // Mask registers; only implemented bits are writable.
  always_ff @(posedge mclk) begin
    if (srst) begin
      evt3_mask_reg <= EVT3_MASK_RST; // [RULE9]
    end else if (wr_byte && wr_idx_reg == IDX_EVT3_MASKS) begin
      evt3_mask_reg <= (evt3_mask_reg & ~EVT3_IMPL) | (wr_data_reg & EVT3_IMPL);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lin_mask_reg <= LIN_MASK_RST;
    end else if (wr_byte && wr_idx_reg == IDX_LIN_MASKS) begin
      lin_mask_reg <= wr_data_reg & LIN_IMPL;
    end
  end

  // Interrupt pin and level output.
  assign pending = |(evt3_flags & ~evt3_mask_reg) | |(lin_flags & ~lin_mask_reg); // [RULE8]

  always_ff @(posedge mclk) begin
    if (srst) begin
      interrupt_out_n <= 1'b1;
      irq             <= 1'b0;
    end else begin
      interrupt_out_n <= ~pending; // [RULE14]
      irq             <= pending;
    end
  end

  // Write channel: address and data are taken in either order, the
  // register is updated once both are held, and the response follows.
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  always_comb begin
    case (wr_idx_reg)
      IDX_BUCK_LIVE, IDX_EVT3_FLAGS, IDX_EVT3_MASKS, IDX_EVT3_LIVE,
      IDX_LIN_FLAGS, IDX_LIN_MASKS, IDX_LIN_LIVE: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_held_reg   <= 1'b0;
      s_axi_awready <= 1'b0;
      wr_idx_reg    <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg   <= 1'b1;
      s_axi_awready <= 1'b0;
      wr_idx_reg    <= s_axi_awaddr[ADDR_LSB +: IDX_W];
    end else if (wr_fire) begin
      aw_held_reg   <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_reg & ~s_axi_bvalid;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      w_held_reg   <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_data_reg  <= REG_ZERO;
      wr_lane_reg  <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg   <= 1'b1;
      s_axi_wready <= 1'b0;
      wr_data_reg  <= s_axi_wdata[REG_W-1:0];
      wr_lane_reg  <= s_axi_wstrb[LANE0];
    end else if (wr_fire) begin
      w_held_reg   <= 1'b0;
    end else begin
      s_axi_wready <= ~w_held_reg & ~s_axi_bvalid;
    end
  end

  // Writes to live registers are accepted and ignored.
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_DECERR; // [RULE3]
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: data is registered one cycle after the address is taken.
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign rd_idx  = s_axi_araddr[ADDR_LSB +: IDX_W];

  always_comb begin
    rd_mapped = 1'b1;
    case (rd_idx)
      IDX_BUCK_LIVE:  rd_byte = buck_live;
      IDX_EVT3_FLAGS: rd_byte = evt3_flags;
      IDX_EVT3_MASKS: rd_byte = evt3_mask_reg;
      IDX_EVT3_LIVE:  rd_byte = evt3_live;
      IDX_LIN_FLAGS:  rd_byte = lin_flags;
      IDX_LIN_MASKS:  rd_byte = lin_mask_reg;
      IDX_LIN_LIVE:   rd_byte = lin_live;
      default: begin
        rd_byte   = REG_ZERO;
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {{(AXI_DATA_W-REG_W){1'b0}}, rd_byte};
      s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid  <= ~s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // The host is trusted not to touch the fuse programming registers while
  // the running bit is set; this block only reports that bit. [RULE12]

  property p_buck_live;
    (ar_fire && rd_idx == IDX_BUCK_LIVE) |=>
      s_axi_rdata[BIT_BUCK3] == $past(buck3_s) && s_axi_rdata[BIT_BUCK2] == $past(buck2_s)
      && s_axi_rdata[BIT_BUCK1_HI] == $past(buck1_s)
      && s_axi_rdata[BIT_BUCK1_LO] == $past(buck1_s);
  endproperty
  a_buck_live : assert property (p_buck_live) else $error("buck live bits wrong"); // [RULE1]

  property p_unused_zero;
    (ar_fire && rd_idx == IDX_BUCK_LIVE) |=>
      s_axi_rdata[7:5] == 3'h0 && s_axi_rdata[2] == 1'b0;
  endproperty
  a_unused_zero : assert property (p_unused_zero) else $error("unused live bits not zero"); // [RULE2]

  property p_lin_live;
    (ar_fire && rd_idx == IDX_LIN_LIVE) |=> s_axi_rdata[LIN_N-1:0] == $past(lin_s);
  endproperty
  a_lin_live : assert property (p_lin_live) else $error("linear live bits wrong"); // [RULE3]

  property p_fuse_err_set;
    ferr_s |=> evt3_flags[BIT_FUSE_ERR];
  endproperty
  a_fuse_err_set : assert property (p_fuse_err_set) else $error("fuse error flag missed"); // [RULE4]

  property p_blow_done_set;
    $fell(frun_s) |=> evt3_flags[BIT_FUSE_DONE] [*2] or (evt3_flags[BIT_FUSE_DONE] ##1 1'b1);
  endproperty
  a_blow_done_set : assert property (p_blow_done_set) else $error("blow done flag missed"); // [RULE5]

  property p_boost_set;
    boost_s |=> evt3_flags[BIT_BOOST];
  endproperty
  a_boost_set : assert property (p_boost_set) else $error("boost flag missed"); // [RULE6]

  property p_w1c_hold;
    (evt3_flags[BIT_BOOST] && !evt3_clr[BIT_BOOST]) |=> evt3_flags[BIT_BOOST];
  endproperty
  a_w1c_hold : assert property (p_w1c_hold) else $error("flag dropped without clear"); // [RULE7]

  property p_w1c_clear;
    (evt3_clr[BIT_BOOST] && !boost_s) |=> !evt3_flags[BIT_BOOST];
  endproperty
  a_w1c_clear : assert property (p_w1c_clear) else $error("flag not cleared"); // [RULE7]

  property p_masked_quiet;
    (evt3_mask_reg == EVT3_MASK_RST && lin_mask_reg == LIN_MASK_RST) |=> interrupt_out_n;
  endproperty
  a_masked_quiet : assert property (p_masked_quiet) else $error("masked flag drove pin"); // [RULE8]

  property p_mask_reset;
    $fell(srst) |-> evt3_mask_reg == EVT3_MASK_RST && lin_mask_reg == LIN_MASK_RST;
  endproperty
  a_mask_reset : assert property (p_mask_reset) else $error("mask reset value wrong"); // [RULE9]

  property p_evt3_live;
    (ar_fire && rd_idx == IDX_EVT3_LIVE) |=>
      s_axi_rdata[BIT_BOOST] == $past(boost_s) && s_axi_rdata[BIT_FUSE_ERR] == $past(ferr_s);
  endproperty
  a_evt3_live : assert property (p_evt3_live) else $error("event live bits wrong"); // [RULE10]

  property p_running_live;
    (ar_fire && rd_idx == IDX_EVT3_LIVE) |=> s_axi_rdata[BIT_FUSE_DONE] == $past(frun_s);
  endproperty
  a_running_live : assert property (p_running_live) else $error("running bit wrong"); // [RULE11]

  property p_lin_set;
    lin_s[0] |=> lin_flags[0];
  endproperty
  a_lin_set : assert property (p_lin_set) else $error("linear flag missed"); // [RULE13]

  property p_pin_follows;
    pending |=> !interrupt_out_n && irq;
  endproperty
  a_pin_follows : assert property (p_pin_follows) else $error("pin not asserted"); // [RULE14]

  property p_pin_release;
    !pending |=> interrupt_out_n && !irq;
  endproperty
  a_pin_release : assert property (p_pin_release) else $error("pin not released"); // [RULE14]

endmodule // fism_top

// ### fism_host.sv
/*
 * Host model: an AXI4-Lite master that services the fault interrupt block.
 * Assumes one clock shared with the block and a slave that answers in its own time.
 */
`timescale 1ns/10ps
module fism_host
  import fism_pkg::*;
#(
  parameter logic [AXI_ADDR_W-1:0] FUSE_PROG_ADDR = 8'hf0
) (
  input  wire logic                  mclk,
  output logic [AXI_ADDR_W-1:0]      awaddr,
  output logic                       awvalid,
  input  wire logic                  awready,
  output logic [AXI_DATA_W-1:0]      wdata,
  output logic [3:0]                 wstrb,
  output logic                       wvalid,
  input  wire logic                  wready,
  input  wire logic [1:0]            bresp,
  input  wire logic                  bvalid,
  output logic                       bready,
  output logic [AXI_ADDR_W-1:0]      araddr,
  output logic                       arvalid,
  input  wire logic                  arready,
  input  wire logic [AXI_DATA_W-1:0] rdata,
  input  wire logic [1:0]            rresp,
  input  wire logic                  rvalid,
  output logic                       rready
);
  // Response ready stays high, so it never has to be toggled between transfers.
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b1;
  end

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
    logic [31:0] s;
    logic [1:0]  q;
    s = 32'h0000_0040;
    // Fuse programming space is left alone until the blow sequence has ended.
    while (a == FUSE_PROG_ADDR && s[BIT_FUSE_DONE]) rd({IDX_EVT3_LIVE, 2'b00}, s, q);
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin
        do @(posedge mclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge mclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge mclk); while (!bvalid);
    r = bresp;
  endtask
endmodule // fism_host

// ### testbench.sv
/*
 * Self-checking testbench for the fault interrupt status, mask and sense block.
 * Assumes the host model drives the register bus and the bench drives the fault levels.
 */
`timescale 1ns/10ps
module testbench;
  import fism_pkg::*;

  localparam logic [7:0] A_BUCK = {IDX_BUCK_LIVE, 2'b00};
  localparam logic [7:0] A_FLG  = {IDX_EVT3_FLAGS, 2'b00};
  localparam logic [7:0] A_MSK  = {IDX_EVT3_MASKS, 2'b00};
  localparam logic [7:0] A_LIV  = {IDX_EVT3_LIVE, 2'b00};
  localparam logic [7:0] A_LFLG = {IDX_LIN_FLAGS, 2'b00};
  localparam logic [7:0] A_LMSK = {IDX_LIN_MASKS, 2'b00};
  localparam logic [7:0] A_LLIV = {IDX_LIN_LIVE, 2'b00};

  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, interrupt_out_n, irq;
  logic        b1 = 1'b0, b2 = 1'b1, b3 = 1'b0, bst = 1'b0, ferr = 1'b0, frun = 1'b0;
  logic [5:0]  lin = 6'h00;
  int          miscompares = 0;
  int          compares = 0;

  always #20 mclk = ~mclk;

  fism_top i_dut (
    .mclk(mclk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .buck1_overcurrent_live(b1), .buck2_overcurrent_live(b2),
    .buck3_overcurrent_live(b3), .boost_overcurrent_live(bst),
    .fuse_error_live(ferr), .fuse_blow_running_live(frun),
    .linear_overcurrent_live(lin), .interrupt_out_n(interrupt_out_n), .irq(irq)
  );

  fism_host i_host (
    .mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t ns: %s got %h expected %h", $time, w, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string w);
    logic [31:0] d;
    logic [1:0]  r;
    i_host.rd(a, d, r);
    chk(d, 32'(e), w);
    chk(32'(r), 32'(RESP_OKAY), w);
  endtask

  task automatic wrc(input logic [7:0] a, input logic [7:0] v, input string w);
    logic [1:0] r;
    i_host.wr(a, v, r);
    chk(32'(r), 32'(RESP_OKAY), w);
  endtask

  // Checks the active-low pin and its active-high twin together.
  task automatic pin(input logic n, input string w);
    chk(32'({irq, interrupt_out_n}), 32'({~n, n}), w);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rdc(A_BUCK, 8'h08, "buck live at reset");
    rdc(A_FLG, 8'h00, "event flags reset");
    rdc(A_MSK, 8'hc5, "event masks reset");
    rdc(A_LFLG, 8'h00, "linear flags reset");
    rdc(A_LMSK, 8'h3f, "linear masks reset");
    pin(1'b1, "pin idle after reset");
    i_host.rd(8'h7c, d, r);
    chk(d, 32'h0000_0000, "unmapped data");
    chk(32'(r), 32'(RESP_DECERR), "unmapped resp");
    $display("test reset finished");
  endtask

  task automatic t_live;
    logic [7:0] e [3] = '{8'h03, 8'h08, 8'h10};
    for (int i = 0; i < 3; i++) begin
      {b3, b2, b1} <= 3'(1 << i);
      tick(3);
      rdc(A_BUCK, e[i], "buck live map");
    end
    {b3, b2, b1} <= 3'b000;
    {bst, ferr, frun} <= 3'b111;
    tick(3);
    rdc(A_BUCK, 8'h00, "buck live follows");
    rdc(A_LIV, 8'hc1, "event live map");
    wrc(A_LIV, 8'h00, "write to live");
    rdc(A_LIV, 8'hc1, "live is read-only");
    {bst, ferr, frun} <= 3'b000;
    tick(3);
    rdc(A_LIV, 8'h00, "event live clears");
    $display("test live finished");
  endtask

  task automatic t_flags;
    rdc(A_FLG, 8'hc1, "flags latched");
    pin(1'b1, "all masked");
    wrc(A_FLG, 8'h00, "write zero");
    rdc(A_FLG, 8'hc1, "zero keeps flags");
    wrc(A_FLG, 8'h40, "clear one");
    rdc(A_FLG, 8'h81, "one flag cleared");
    wrc(A_FLG, 8'hff, "clear all");
    rdc(A_FLG, 8'h00, "all cleared");
    wrc(A_MSK, 8'h00, "masks zero");
    rdc(A_MSK, 8'h04, "mask readback");
    wrc(A_MSK, 8'hff, "masks set");
    rdc(A_MSK, 8'hc5, "mask unused bits");
    bst <= 1'b1;
    tick(1);
    bst <= 1'b0;
    tick(5);
    rdc(A_FLG, 8'h01, "boost pulse latched");
    pin(1'b1, "masked flag quiet");
    wrc(A_MSK, 8'hc4, "unmask boost");
    tick(2);
    pin(1'b0, "unmasked flag drives pin");
    wrc(A_FLG, 8'h01, "clear boost");
    tick(2);
    pin(1'b1, "pin released");
    $display("test flags finished");
  endtask

  task automatic t_race;
    bst <= 1'b1;
    tick(5);
    wrc(A_FLG, 8'h01, "clear during fault");
    rdc(A_FLG, 8'h01, "set beats clear");
    pin(1'b0, "pin held by fault");
    bst <= 1'b0;
    tick(4);
    wrc(A_FLG, 8'h01, "clear after fault");
    rdc(A_FLG, 8'h00, "cleared");
    lin <= 6'h21;
    tick(3);
    rdc(A_LLIV, 8'h21, "linear live");
    lin <= 6'h00;
    tick(5);
    rdc(A_LFLG, 8'h21, "linear latched");
    wrc(A_LFLG, 8'h01, "linear clear one");
    rdc(A_LFLG, 8'h20, "linear one cleared");
    wrc(A_LMSK, 8'h1f, "unmask linear top");
    tick(2);
    pin(1'b0, "linear drives pin");
    wrc(A_LFLG, 8'h20, "linear clear top");
    tick(2);
    pin(1'b1, "linear released");
    $display("test race finished");
  endtask

  // The host must hold its fuse space access until the blow sequence ends.
  task automatic t_blow;
    logic [1:0] r;
    frun <= 1'b1;
    tick(3);
    fork
      begin
        tick(30);
        frun <= 1'b0;
      end
      i_host.wr(i_host.FUSE_PROG_ADDR, 8'h00, r);
    join
    chk(32'(frun), 32'h0000_0000, "write waited for blow end");
    chk(32'(r), 32'(RESP_DECERR), "fuse space resp");
    rdc(A_FLG, 8'h40, "blow done latched");
    wrc(A_FLG, 8'h40, "clear done");
    rdc(A_FLG, 8'h00, "done cleared");
    pin(1'b1, "masked done quiet");
    $display("test blow finished");
  endtask

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    tick(10);
    srst <= 1'b0;
    tick(2);
    t_reset();
    t_live();
    t_flags();
    t_race();
    t_blow();
    end_sim();
  end

  // Watchdog: the tests take well under a thousand cycles.
  initial begin
    #(40 * 20000);
    miscompares++;
    $display("ERROR at %0t ns: watchdog expired", $time);
    end_sim();
  end
endmodule // testbench
